//--- isr_pkg.sv
// ==========================================================
// status reporting constants and carriers
package isr_pkg;

  // ==========================================================
  // widths
  localparam int REG_W = 16;
  localparam int BYTE_W = 8;

  // ==========================================================
  // questionable group bit positions
  localparam int QUEST_OV_BIT = 0;
  localparam int QUEST_OC_BIT = 1;
  localparam int QUEST_OVERTEMP_BIT = 4;
  localparam int QUEST_INHIBIT_BIT = 9;
  localparam int QUEST_UNREG_BIT = 10;

  // ==========================================================
  // operation group bit positions
  localparam int OPST_TRIG_WAIT_BIT = 5;
  localparam int OPST_CONST_VOLT_BIT = 8;
  localparam int OPST_CONST_CURR_BIT = 10;

  // ==========================================================
  // status byte bit positions
  localparam int STB_QUEST_BIT = 3;
  localparam int STB_MSG_BIT = 4;
  localparam int STB_EVENT_BIT = 5;
  localparam int STB_SERVICE_BIT = 6;
  localparam int STB_OPST_BIT = 7;

  // ==========================================================
  // reset values
  localparam logic [REG_W-1:0] RISE_RST = 16'hFFFF;
  localparam logic [REG_W-1:0] FALL_RST = 16'h0000;
  localparam logic [REG_W-1:0] ENABLE_RST = 16'h0000;
  localparam logic [BYTE_W-1:0] STD_EVENT_RST = 8'h00;
  localparam logic [BYTE_W-1:0] STD_ENABLE_RST = 8'h00;
  localparam logic [BYTE_W-1:0] SRE_CLEARED = 8'h00;
  localparam logic POWER_ON_CLEAR = 1'b1;

  // ==========================================================
  // commands and queries
  typedef enum logic [4:0] {
    CMD_NOP = 5'h00,
    CMD_QUEST_COND_RD = 5'h01,
    CMD_QUEST_RISE_WR = 5'h02,
    CMD_QUEST_RISE_RD = 5'h03,
    CMD_QUEST_FALL_WR = 5'h04,
    CMD_QUEST_FALL_RD = 5'h05,
    CMD_QUEST_EVENT_RD = 5'h06,
    CMD_QUEST_EN_WR = 5'h07,
    CMD_QUEST_EN_RD = 5'h08,
    CMD_OPST_COND_RD = 5'h09,
    CMD_OPST_RISE_WR = 5'h0A,
    CMD_OPST_RISE_RD = 5'h0B,
    CMD_OPST_FALL_WR = 5'h0C,
    CMD_OPST_FALL_RD = 5'h0D,
    CMD_OPST_EVENT_RD = 5'h0E,
    CMD_OPST_EN_WR = 5'h0F,
    CMD_OPST_EN_RD = 5'h10,
    CMD_STD_EVENT_RD = 5'h11,
    CMD_STD_EN_WR = 5'h12,
    CMD_STD_EN_RD = 5'h13,
    CMD_STB_RD = 5'h14,
    CMD_SRE_WR = 5'h15,
    CMD_SRE_RD = 5'h16,
    CMD_CLEAR_STATUS = 5'h17,
    CMD_SERIAL_POLL = 5'h18
  } isr_cmd_e;

  // ==========================================================
  // request and answer carriers
  typedef struct packed {
    logic valid;
    isr_cmd_e code;
    logic [REG_W-1:0] data;
  } isr_cmd_s;

  typedef struct packed {
    logic valid;
    logic [REG_W-1:0] data;
  } isr_rsp_s;

endpackage : isr_pkg

//--- isr_filter_group.sv
`timescale 1ns/1ps
// ==========================================================
// transition filtered status group
module isr_filter_group #(
  parameter int W = 16
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // monitored signals
  input wire logic [W-1:0] cond_in,
  // register access strobes
  input wire logic rise_wr,
  input wire logic fall_wr,
  input wire logic en_wr,
  input wire logic ev_rd,
  input wire logic cls,
  input wire logic [W-1:0] wdata,
  // register contents
  output logic [W-1:0] cond_o,
  output logic [W-1:0] rise_o,
  output logic [W-1:0] fall_o,
  output logic [W-1:0] ev_o,
  output logic [W-1:0] en_o,
  output logic summary_o
);

  logic [W-1:0] cond_r;
  logic [W-1:0] rise_r;
  logic [W-1:0] fall_r;
  logic [W-1:0] ev_r;
  logic [W-1:0] en_r;
  logic [W-1:0] ev_set;
  logic [W-1:0] ev_nxt;

  // ==========================================================
  // elaboration check
  if (W < 1 || W > isr_pkg::REG_W) begin : g_bad_width
    $error("filter group width out of range");
  end

  // live condition snapshot, no write path
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      cond_r <= '0;
    end else begin
      cond_r <= cond_in;
    end
  end

  // filters and enable, changed only by writes
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      rise_r <= isr_pkg::RISE_RST[W-1:0];
      fall_r <= isr_pkg::FALL_RST[W-1:0];
      en_r <= isr_pkg::ENABLE_RST[W-1:0];
    end else begin
      if (rise_wr) rise_r <= wdata;
      if (fall_wr) fall_r <= wdata;
      if (en_wr) en_r <= wdata;
    end
  end

  // edge detect, recurrence of a persisting risen cause
  always_comb begin
    ev_set = (rise_r & cond_in & ~cond_r)
           | (fall_r & ~cond_in & cond_r);
    if (ev_rd) begin
      ev_set = ev_set | (rise_r & cond_r);
    end
    ev_nxt = (cls || ev_rd) ? '0 : ev_r;
    ev_nxt = ev_nxt | ev_set;
  end

  // event latch, set wins over clear
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      ev_r <= '0;
    end else begin
      ev_r <= ev_nxt;
    end
  end

  assign cond_o = cond_r;
  assign rise_o = rise_r;
  assign fall_o = fall_r;
  assign ev_o = ev_r;
  assign en_o = en_r;
  assign summary_o = |(ev_r & en_r);

  // ==========================================================
  // checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  a_cond_mirror: assert property (
    rst_n |=> cond_r == $past(cond_in))
    else $error("condition does not follow input");

  a_rise_sets_event: assert property (
    rst_n && (rise_r & cond_in & ~cond_r) != '0
    |=> (ev_r & $past(rise_r & cond_in & ~cond_r))
        == $past(rise_r & cond_in & ~cond_r))
    else $error("rising edge not latched");

  a_read_clears: assert property (
    ev_rd && ev_set == '0 |=> ev_r == '0)
    else $error("event read did not clear");

  a_mask_kept: assert property (
    cls && !en_wr && !rise_wr |=> en_r == $past(en_r)
      && rise_r == $past(rise_r))
    else $error("clear status touched a mask");

endmodule : isr_filter_group

//--- isr_status_top.sv
`timescale 1ns/1ps
module isr_status_top #(
  parameter int COND_W = 16
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // questionable supply flags
  input wire logic overvoltage_flag,
  input wire logic overcurrent_flag,
  input wire logic overtemperature_flag,
  input wire logic remote_inhibit_flag,
  input wire logic unregulated_flag,
  // operation supply flags
  input wire logic waiting_for_trigger_flag,
  input wire logic constant_voltage_flag,
  input wire logic constant_current_flag,
  // interface events and output queue state
  input wire logic [isr_pkg::BYTE_W-1:0] std_event_set,
  input wire logic message_available,
  // power-on settings
  input wire logic power_on_clear_setting,
  input wire logic [isr_pkg::BYTE_W-1:0] sre_saved,
  // command port
  input wire isr_pkg::isr_cmd_s cmd,
  // answer and service request
  output isr_pkg::isr_rsp_s rsp,
  output logic srq
);

  // ==========================================================
  // declarations
  localparam int BW = isr_pkg::BYTE_W;

  logic [COND_W-1:0] quest_cond_in;
  logic [COND_W-1:0] opst_cond_in;
  logic [COND_W-1:0] wdata;
  logic [COND_W-1:0] quest_cond;
  logic [COND_W-1:0] quest_rise;
  logic [COND_W-1:0] quest_fall;
  logic [COND_W-1:0] quest_event;
  logic [COND_W-1:0] quest_enable;
  logic [COND_W-1:0] opst_cond;
  logic [COND_W-1:0] opst_rise;
  logic [COND_W-1:0] opst_fall;
  logic [COND_W-1:0] opst_event;
  logic [COND_W-1:0] opst_enable;
  logic questionable_summary;
  logic operation_summary;
  logic [BW-1:0] std_event_r;
  logic [BW-1:0] std_enable_r;
  logic [BW-1:0] sre_r;
  logic [BW-1:0] std_event_nxt;
  logic [BW-1:0] stb_base;
  logic event_summary_bit;
  logic master_summary_bit;
  logic master_summary_q_r;
  logic master_rise;
  logic request_service_latch_r;
  logic request_service_nxt;
  logic is_cmd_quest_rise_wr;
  logic is_cmd_quest_fall_wr;
  logic is_cmd_quest_en_wr;
  logic is_cmd_quest_ev_rd;
  logic is_cmd_opst_rise_wr;
  logic is_cmd_opst_fall_wr;
  logic is_cmd_opst_en_wr;
  logic is_cmd_opst_ev_rd;
  logic is_cmd_std_ev_rd;
  logic is_cmd_std_en_wr;
  logic is_cmd_sre_wr;
  logic is_cmd_cls;
  logic is_cmd_poll;
  logic is_cmd_stb_rd;
  logic rd_valid;
  logic [isr_pkg::REG_W-1:0] rd_data;
  isr_pkg::isr_rsp_s rsp_r;

  // ==========================================================
  // elaboration check
  if (COND_W <= isr_pkg::QUEST_UNREG_BIT
      || COND_W > isr_pkg::REG_W) begin : g_bad_width
    $error("condition width cannot hold the flags");
  end

  // ==========================================================
  // condition vectors from supply flags
  always_comb begin
    quest_cond_in = '0;
    quest_cond_in[isr_pkg::QUEST_OV_BIT] = overvoltage_flag;
    quest_cond_in[isr_pkg::QUEST_OC_BIT] = overcurrent_flag;
    quest_cond_in[isr_pkg::QUEST_OVERTEMP_BIT] = overtemperature_flag;
    quest_cond_in[isr_pkg::QUEST_INHIBIT_BIT] = remote_inhibit_flag;
    quest_cond_in[isr_pkg::QUEST_UNREG_BIT] = unregulated_flag;
  end

  // operation flags
  always_comb begin
    opst_cond_in = '0;
    opst_cond_in[isr_pkg::OPST_TRIG_WAIT_BIT] =
      waiting_for_trigger_flag;
    opst_cond_in[isr_pkg::OPST_CONST_VOLT_BIT] =
      constant_voltage_flag;
    opst_cond_in[isr_pkg::OPST_CONST_CURR_BIT] =
      constant_current_flag;
  end

  // ==========================================================
  // command decode
  assign wdata = cmd.data[COND_W-1:0];
  assign is_cmd_quest_rise_wr =
    cmd.valid && cmd.code == isr_pkg::CMD_QUEST_RISE_WR;
  assign is_cmd_quest_fall_wr =
    cmd.valid && cmd.code == isr_pkg::CMD_QUEST_FALL_WR;
  assign is_cmd_quest_en_wr =
    cmd.valid && cmd.code == isr_pkg::CMD_QUEST_EN_WR;
  assign is_cmd_quest_ev_rd =
    cmd.valid && cmd.code == isr_pkg::CMD_QUEST_EVENT_RD;
  assign is_cmd_opst_rise_wr =
    cmd.valid && cmd.code == isr_pkg::CMD_OPST_RISE_WR;
  assign is_cmd_opst_fall_wr =
    cmd.valid && cmd.code == isr_pkg::CMD_OPST_FALL_WR;
  assign is_cmd_opst_en_wr =
    cmd.valid && cmd.code == isr_pkg::CMD_OPST_EN_WR;
  assign is_cmd_opst_ev_rd =
    cmd.valid && cmd.code == isr_pkg::CMD_OPST_EVENT_RD;
  // common commands for the standard group
  assign is_cmd_std_ev_rd =
    cmd.valid && cmd.code == isr_pkg::CMD_STD_EVENT_RD;
  assign is_cmd_std_en_wr =
    cmd.valid && cmd.code == isr_pkg::CMD_STD_EN_WR;
  assign is_cmd_sre_wr = cmd.valid && cmd.code == isr_pkg::CMD_SRE_WR;
  assign is_cmd_cls = cmd.valid && cmd.code == isr_pkg::CMD_CLEAR_STATUS;
  assign is_cmd_poll = cmd.valid && cmd.code == isr_pkg::CMD_SERIAL_POLL;
  assign is_cmd_stb_rd = cmd.valid && cmd.code == isr_pkg::CMD_STB_RD;

  // ==========================================================
  // filtered groups
  isr_filter_group #(.W(COND_W)) u_quest (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .cond_in(quest_cond_in),
    .rise_wr(is_cmd_quest_rise_wr),
    .fall_wr(is_cmd_quest_fall_wr),
    .en_wr(is_cmd_quest_en_wr),
    .ev_rd(is_cmd_quest_ev_rd),
    .cls(is_cmd_cls),
    .wdata(wdata),
    .cond_o(quest_cond),
    .rise_o(quest_rise),
    .fall_o(quest_fall),
    .ev_o(quest_event),
    .en_o(quest_enable),
    .summary_o(questionable_summary)
  );

  // same structure for the operation group
  isr_filter_group #(.W(COND_W)) u_opst (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .cond_in(opst_cond_in),
    .rise_wr(is_cmd_opst_rise_wr),
    .fall_wr(is_cmd_opst_fall_wr),
    .en_wr(is_cmd_opst_en_wr),
    .ev_rd(is_cmd_opst_ev_rd),
    .cls(is_cmd_cls),
    .wdata(wdata),
    .cond_o(opst_cond),
    .rise_o(opst_rise),
    .fall_o(opst_fall),
    .ev_o(opst_event),
    .en_o(opst_enable),
    .summary_o(operation_summary)
  );

  // ==========================================================
  // standard event latch, set wins over read or clear
  always_comb begin
    std_event_nxt = (is_cmd_std_ev_rd || is_cmd_cls) ? '0
                    : std_event_r;
    std_event_nxt = std_event_nxt | std_event_set;
  end

  // standard event latch
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      std_event_r <= isr_pkg::STD_EVENT_RST;
    end else begin
      std_event_r <= std_event_nxt;
    end
  end

  // standard enable, written only
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      std_enable_r <= isr_pkg::STD_ENABLE_RST;
    end else if (is_cmd_std_en_wr) begin
      std_enable_r <= cmd.data[BW-1:0];
    end
  end

  assign event_summary_bit = |(std_event_r & std_enable_r);

  // ==========================================================
  // service request enable, power-on value chosen by setting
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      if (power_on_clear_setting == isr_pkg::POWER_ON_CLEAR) begin
        sre_r <= isr_pkg::SRE_CLEARED;
      end else begin
        sre_r <= sre_saved;
      end
    end else if (is_cmd_sre_wr) begin
      sre_r <= cmd.data[BW-1:0];
    end
  end

  // ==========================================================
  // status byte without bit 6
  always_comb begin
    stb_base = '0;
    stb_base[isr_pkg::STB_QUEST_BIT] = questionable_summary;
    stb_base[isr_pkg::STB_MSG_BIT] = message_available;
    stb_base[isr_pkg::STB_EVENT_BIT] = event_summary_bit;
    stb_base[isr_pkg::STB_OPST_BIT] = operation_summary;
  end

  // live master summary and its rising edge
  assign master_summary_bit = |(stb_base & sre_r);
  assign master_rise = master_summary_bit & ~master_summary_q_r;
  assign request_service_nxt = master_rise
    | (request_service_latch_r & ~is_cmd_poll);

  // request latch and edge history
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      master_summary_q_r <= 1'b0;
      request_service_latch_r <= 1'b0;
    end else begin
      master_summary_q_r <= master_summary_bit;
      request_service_latch_r <= request_service_nxt;
    end
  end

  assign srq = request_service_latch_r;

  // ==========================================================
  // query answer mux
  always_comb begin
    rd_valid = cmd.valid;
    rd_data = '0;
    case (cmd.code)
      isr_pkg::CMD_QUEST_COND_RD: rd_data[COND_W-1:0] = quest_cond;
      isr_pkg::CMD_QUEST_RISE_RD: rd_data[COND_W-1:0] = quest_rise;
      isr_pkg::CMD_QUEST_FALL_RD: rd_data[COND_W-1:0] = quest_fall;
      isr_pkg::CMD_QUEST_EVENT_RD: rd_data[COND_W-1:0] = quest_event;
      isr_pkg::CMD_QUEST_EN_RD: rd_data[COND_W-1:0] = quest_enable;
      isr_pkg::CMD_OPST_COND_RD: rd_data[COND_W-1:0] = opst_cond;
      isr_pkg::CMD_OPST_RISE_RD: rd_data[COND_W-1:0] = opst_rise;
      isr_pkg::CMD_OPST_FALL_RD: rd_data[COND_W-1:0] = opst_fall;
      isr_pkg::CMD_OPST_EVENT_RD: rd_data[COND_W-1:0] = opst_event;
      isr_pkg::CMD_OPST_EN_RD: rd_data[COND_W-1:0] = opst_enable;
      isr_pkg::CMD_STD_EVENT_RD: rd_data[BW-1:0] = std_event_r;
      isr_pkg::CMD_STD_EN_RD: rd_data[BW-1:0] = std_enable_r;
      isr_pkg::CMD_SRE_RD: rd_data[BW-1:0] = sre_r;
      isr_pkg::CMD_STB_RD: begin
        rd_data[BW-1:0] = stb_base;
        rd_data[isr_pkg::STB_SERVICE_BIT] = master_summary_bit;
      end
      isr_pkg::CMD_SERIAL_POLL: begin
        rd_data[BW-1:0] = stb_base;
        rd_data[isr_pkg::STB_SERVICE_BIT] =
          request_service_latch_r;
      end
      default: rd_valid = 1'b0;
    endcase
  end

  // registered answer, one cycle after the request
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      rsp_r <= '0;
    end else begin
      rsp_r.valid <= rd_valid;
      rsp_r.data <= rd_data;
    end
  end

  assign rsp = rsp_r;

  // ==========================================================
  // checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  a_poll_bit_six: assert property (
    is_cmd_poll |=> rsp_r.valid
      && rsp_r.data[isr_pkg::STB_SERVICE_BIT]
         == $past(request_service_latch_r))
    else $error("poll bit 6 is not the request latch");

  a_query_bit_six: assert property (
    is_cmd_stb_rd |=> rsp_r.valid
      && rsp_r.data[isr_pkg::STB_SERVICE_BIT]
         == $past(|(stb_base & sre_r)))
    else $error("query bit 6 is not the master summary");

  a_poll_clears: assert property (
    is_cmd_poll && !master_rise |=> !request_service_latch_r)
    else $error("poll left the request latch set");

  a_query_keeps: assert property (
    is_cmd_stb_rd && request_service_latch_r
    |=> request_service_latch_r)
    else $error("byte query cleared the request latch");

  a_request_cause: assert property (
    $rose(srq) |-> $past(master_summary_bit)
      && !$past(master_summary_q_r))
    else $error("request raised without new summary");

  a_sre_zero_quiet: assert property (
    sre_r == '0 && !srq |=> !srq)
    else $error("request raised with empty enable");

  a_std_read_clear: assert property (
    is_cmd_std_ev_rd && std_event_set == '0 |=> std_event_r == '0)
    else $error("standard event read did not clear");

  a_quest_to_byte: assert property (
    (quest_event & quest_enable) != '0 && is_cmd_stb_rd
    |=> rsp_r.data[isr_pkg::STB_QUEST_BIT])
    else $error("questionable summary missing from byte");

endmodule : isr_status_top

//--- isr_ctrl_model.sv
`timescale 1ns/1ps
// ==========================================================
// system controller model on the command port
module isr_ctrl_model (
  // clock
  input wire logic clk_sys,
  // device answer
  input wire isr_pkg::isr_rsp_s rsp,
  // device command
  output isr_pkg::isr_cmd_s cmd
);
  // idle bus carries no stale data
  initial cmd = '{1'b0, isr_pkg::CMD_NOP, 16'hFFFF};

  // one command from a rising edge, answer one edge later
  task automatic xfer(input isr_pkg::isr_cmd_e code,
    input logic [15:0] wd, output logic [15:0] rdat);
    cmd <= '{1'b1, code, wd};
    @(posedge clk_sys);
    cmd <= '{1'b0, isr_pkg::CMD_NOP, ~wd};
    #1;
    rdat = (rsp.valid === 1'b1) ? rsp.data : 16'hXXXX;
    @(posedge clk_sys);
  endtask : xfer

  // service a request by serial poll
  task automatic poll(output logic [15:0] rdat);
    xfer(isr_pkg::CMD_SERIAL_POLL, 16'h0000, rdat);
  endtask : poll
endmodule : isr_ctrl_model

//--- instrument_status_reporting_bench.sv
`timescale 1ns/1ps
// ==========================================================
// self-checking bench for the status reporting block
module instrument_status_reporting_bench;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic [15:0] qf = 16'h0000;
  logic [15:0] of = 16'h0000;
  logic [7:0] std_set = 8'h00;
  logic mav = 1'b0;
  logic poc = 1'b1;
  logic [7:0] saved = 8'hA5;
  isr_pkg::isr_cmd_s cmd;
  isr_pkg::isr_rsp_s rsp;
  logic srq;
  int miscompares = 0;
  int checks_done = 0;
  logic [15:0] d;

  // 200 MHz clock
  always #2.5 clk_sys = ~clk_sys;

  // ==========================================================
  // design and controller
  isr_status_top u_isr_status_top (
    .clk_sys(clk_sys), .rst_n(rst_n),
    .overvoltage_flag(qf[0]), .overcurrent_flag(qf[1]),
    .overtemperature_flag(qf[4]), .remote_inhibit_flag(qf[9]),
    .unregulated_flag(qf[10]), .waiting_for_trigger_flag(of[5]),
    .constant_voltage_flag(of[8]), .constant_current_flag(of[10]),
    .std_event_set(std_set), .message_available(mav),
    .power_on_clear_setting(poc), .sre_saved(saved),
    .cmd(cmd), .rsp(rsp), .srq(srq)
  );
  isr_ctrl_model u_isr_ctrl_model (
    .clk_sys(clk_sys), .rsp(rsp), .cmd(cmd)
  );

  // ==========================================================
  // access and compare tasks
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic wr(input isr_pkg::isr_cmd_e c, input logic [15:0] v);
    logic [15:0] x;
    u_isr_ctrl_model.xfer(c, v, x);
  endtask : wr

  task automatic q(input isr_pkg::isr_cmd_e c, input logic [15:0] e,
    input logic [15:0] m);
    logic [15:0] x;
    u_isr_ctrl_model.xfer(c, 16'h0000, x);
    chk(x & m, e & m);
  endtask : q

  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
  endtask : tick

  // one filter example: onset, recurrence, removal
  task automatic ex(input logic [15:0] en, input logic [15:0] rs,
    input logic [15:0] fl, input int b);
    logic [15:0] m;
    logic on;
    logic any;
    m = 16'h0001 << b;
    on = |(en & rs & m);
    any = |(en & (rs | fl) & m);
    wr(isr_pkg::CMD_QUEST_EN_WR, en);
    wr(isr_pkg::CMD_QUEST_RISE_WR, rs);
    wr(isr_pkg::CMD_QUEST_FALL_WR, fl);
    wr(isr_pkg::CMD_QUEST_EVENT_RD, 16'h0000);
    qf <= m;
    tick(3);
    q(isr_pkg::CMD_STB_RD, {12'h000, on, 3'h0}, 16'h0008);
    q(isr_pkg::CMD_QUEST_EVENT_RD, rs & m, 16'hFFFF);
    q(isr_pkg::CMD_STB_RD, {12'h000, on, 3'h0}, 16'h0008);
    qf <= 16'h0000;
    tick(3);
    q(isr_pkg::CMD_STB_RD, {12'h000, any, 3'h0}, 16'h0008);
    q(isr_pkg::CMD_QUEST_EVENT_RD, (rs | fl) & m, 16'hFFFF);
    q(isr_pkg::CMD_STB_RD, 16'h0000, 16'h0008);
  endtask : ex

  task automatic final_report;
    $display("checks %0d, mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : final_report

  // ==========================================================
  // main sequence
  initial begin
    tick(6);
    rst_n <= 1'b1;
    @(posedge clk_sys);
    q(isr_pkg::CMD_QUEST_RISE_RD, 16'hFFFF, 16'hFFFF);
    q(isr_pkg::CMD_QUEST_FALL_RD, 16'h0000, 16'hFFFF);
    q(isr_pkg::CMD_SRE_RD, 16'h0000, 16'h00FF);
    qf <= 16'h0613;
    of <= 16'h0520;
    tick(3);
    q(isr_pkg::CMD_QUEST_COND_RD, 16'h0613, 16'hFFFF);
    q(isr_pkg::CMD_OPST_COND_RD, 16'h0520, 16'hFFFF);
    wr(isr_pkg::CMD_OPST_EN_WR, 16'h0100);
    q(isr_pkg::CMD_STB_RD, 16'h0080, 16'h0080);
    qf <= 16'h0000;
    of <= 16'h0000;
    tick(3);
    q(isr_pkg::CMD_QUEST_COND_RD, 16'h0000, 16'hFFFF);
    q(isr_pkg::CMD_QUEST_EVENT_RD, 16'h0613, 16'hFFFF);
    q(isr_pkg::CMD_QUEST_EVENT_RD, 16'h0000, 16'hFFFF);
    q(isr_pkg::CMD_OPST_EVENT_RD, 16'h0520, 16'hFFFF);
    q(isr_pkg::CMD_STB_RD, 16'h0000, 16'h0080);
    wr(isr_pkg::CMD_OPST_RISE_WR, 16'h0000);
    wr(isr_pkg::CMD_OPST_FALL_WR, 16'h0100);
    q(isr_pkg::CMD_OPST_RISE_RD, 16'h0000, 16'hFFFF);
    q(isr_pkg::CMD_OPST_FALL_RD, 16'h0100, 16'hFFFF);
    q(isr_pkg::CMD_OPST_EN_RD, 16'h0100, 16'hFFFF);
    of <= 16'h0100;
    tick(3);
    q(isr_pkg::CMD_OPST_EVENT_RD, 16'h0000, 16'hFFFF);
    of <= 16'h0000;
    tick(3);
    q(isr_pkg::CMD_STB_RD, 16'h0080, 16'h0080);
    q(isr_pkg::CMD_OPST_EVENT_RD, 16'h0100, 16'hFFFF);
    ex(16'h0000, 16'hFFFF, 16'hFFFF, 9);
    ex(16'h0010, 16'h0010, 16'h0000, 4);
    ex(16'h0400, 16'h0400, 16'h0400, 10);
    ex(16'h0200, 16'h0000, 16'h0200, 9);
    chk({15'h0000, srq}, 16'h0000);
    wr(isr_pkg::CMD_STD_EN_WR, 16'h003C);
    q(isr_pkg::CMD_STD_EN_RD, 16'h003C, 16'h00FF);
    std_set <= 8'h04;
    @(posedge clk_sys);
    std_set <= 8'h00;
    tick(2);
    q(isr_pkg::CMD_STB_RD, 16'h0020, 16'h00FF);
    wr(isr_pkg::CMD_SRE_WR, 16'h0020);
    tick(2);
    chk({15'h0000, srq}, 16'h0001);
    q(isr_pkg::CMD_STB_RD, 16'h0060, 16'h00FF);
    chk({15'h0000, srq}, 16'h0001);
    u_isr_ctrl_model.poll(d);
    chk(d, 16'h0060);
    chk({15'h0000, srq}, 16'h0000);
    u_isr_ctrl_model.poll(d);
    chk(d, 16'h0020);
    q(isr_pkg::CMD_STB_RD, 16'h0060, 16'h00FF);
    q(isr_pkg::CMD_STD_EVENT_RD, 16'h0004, 16'h00FF);
    q(isr_pkg::CMD_STD_EVENT_RD, 16'h0000, 16'h00FF);
    q(isr_pkg::CMD_STB_RD, 16'h0000, 16'h00FF);
    wr(isr_pkg::CMD_STD_EN_WR, 16'h0081);
    std_set <= 8'h3C;
    @(posedge clk_sys);
    std_set <= 8'h00;
    tick(2);
    q(isr_pkg::CMD_STB_RD, 16'h0000, 16'h00FF);
    wr(isr_pkg::CMD_CLEAR_STATUS, 16'h0000);
    q(isr_pkg::CMD_STD_EVENT_RD, 16'h0000, 16'h00FF);
    q(isr_pkg::CMD_STD_EN_RD, 16'h0081, 16'h00FF);
    q(isr_pkg::CMD_QUEST_EN_RD, 16'h0200, 16'hFFFF);
    q(isr_pkg::CMD_QUEST_FALL_RD, 16'h0200, 16'hFFFF);
    mav <= 1'b1;
    tick(1);
    q(isr_pkg::CMD_STB_RD, 16'h0010, 16'h00FF);
    wr(isr_pkg::CMD_SRE_WR, 16'h0010);
    q(isr_pkg::CMD_STB_RD, 16'h0050, 16'h00FF);
    poc <= 1'b0;
    saved <= 8'h5A;
    rst_n <= 1'b0;
    tick(6);
    rst_n <= 1'b1;
    @(posedge clk_sys);
    q(isr_pkg::CMD_SRE_RD, 16'h005A, 16'h00FF);
    final_report;
  end

  // hang guard
  initial begin
    repeat (20000) @(posedge clk_sys);
    miscompares++;
    final_report;
  end
endmodule : instrument_status_reporting_bench
